// ===== common/lics_pkg.sv
// constants and types shared by the charge-cycle sequencer
package lics_pkg;

  // ****************************************
  // time base
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FLASH_HZ = 1;
  // one flash phase is half a flash period
  localparam int unsigned HALF_PERIOD_CYCLES = CLK_HZ / (2 * FLASH_HZ);
  // safety periods in tenths of an hour, per 0.1 uF of timing capacitance
  localparam int unsigned PRECON_TENTHS_H = 10;
  localparam int unsigned FAST_TENTHS_H = 15;
  localparam int unsigned ELAPSED_TENTHS_H = 30;
  localparam int unsigned HALF_PERIODS_PER_TENTH_H = 360 * 2 * FLASH_HZ;
  localparam logic [14:0] PRECON_TICKS = 15'(PRECON_TENTHS_H * HALF_PERIODS_PER_TENTH_H);
  localparam logic [14:0] FAST_TICKS = 15'(FAST_TENTHS_H * HALF_PERIODS_PER_TENTH_H);
  localparam logic [14:0] ELAPSED_TICKS = 15'(ELAPSED_TENTHS_H * HALF_PERIODS_PER_TENTH_H);

  // ****************************************
  // current scaling, percent of fast setpoint
  // ****************************************
  localparam logic [6:0] PRECON_PCT = 7'h0A;
  localparam logic [6:0] FAST_PCT = 7'h64;
  localparam logic [6:0] TERM_PCT = 7'h07;

  // ****************************************
  // register map, byte offsets
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SCALE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ELAPSED = 8'h0C;
  localparam int unsigned CTRL_SINGLE_BIT = 0;
  localparam int unsigned CTRL_FLASH_FAULT_BIT = 1;
  localparam int unsigned SCALE_CAP_LSB = 0;
  localparam int unsigned SCALE_RATE_LSB = 8;
  localparam int unsigned STATUS_TEMP_BAD_BIT = 8;
  localparam int unsigned STATUS_PIN_LSB = 9;
  localparam logic [7:0] CAP_TENTHS_RESET = 8'h01;
  localparam logic [3:0] THERMAL_RATE_RESET = 4'h8;

  // ****************************************
  // synchronised input vector positions
  // ****************************************
  localparam int unsigned IN_LOCKOUT = 0;
  localparam int unsigned IN_ENABLE = 1;
  localparam int unsigned IN_TEMP_OK = 2;
  localparam int unsigned IN_TEMP_OFF = 3;
  localparam int unsigned IN_ABOVE_PRECON = 4;
  localparam int unsigned IN_AT_REG = 5;
  localparam int unsigned IN_BELOW_RECHG = 6;
  localparam int unsigned IN_BELOW_TERM = 7;
  localparam int unsigned IN_THERMAL = 8;
  localparam int unsigned IN_VSEL = 9;
  localparam int unsigned IN_CHG_PIN = 10;
  localparam int unsigned IN_FLT_PIN = 11;
  localparam int unsigned IN_W = 12;

  typedef enum logic [6:0] {
    LICS_DISABLED = 7'h01,
    LICS_QUAL = 7'h02,
    LICS_PRECON = 7'h04,
    LICS_FAST = 7'h08,
    LICS_CV = 7'h10,
    LICS_DONE = 7'h20,
    LICS_FAULT = 7'h40
  } lics_state_t;

endpackage

// ===== hw/lics_sequencer.sv
// charge-cycle sequencer with wishbone register slave
module lics_sequencer
  import lics_pkg::*;
#(
  parameter int unsigned HALF_PERIOD = HALF_PERIOD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic supply_lockout,
  input wire logic enable,
  input wire logic cell_temp_in_window,
  input wire logic cell_temp_sense_disabled,
  input wire logic cell_above_precondition,
  input wire logic cell_at_regulation,
  input wire logic cell_below_recharge,
  input wire logic current_below_termination,
  input wire logic die_thermal_regulation,
  input wire logic target_voltage_select,
  input wire logic charge_indicator_in,
  output logic charge_indicator_out,
  output logic charge_indicator_oe_n,
  input wire logic fault_indicator_in,
  output logic fault_indicator_out,
  output logic fault_indicator_oe_n,
  output logic precondition_current_en,
  output logic fast_current_en,
  output logic voltage_regulation_en,
  output logic target_4v2_sel,
  output logic [6:0] current_limit_pct,
  output logic [6:0] termination_pct
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    lics_state_t state;
    logic [23:0] prescale;
    logic [7:0] scale_cnt;
    logic [3:0] cell_temp_sense_acc;
    logic flash;
    logic [14:0] precon_cnt;
    logic [14:0] fast_cnt;
    logic [14:0] elapsed_cnt;
    logic variant_single;
    logic fault_flash;
    logic [7:0] cap_tenths;
    logic [3:0] thermal_rate;
    logic ack;
    logic [31:0] dat;
    logic chg_oe_n;
    logic flt_oe_n;
    logic precon_en;
    logic fast_en;
    logic cv_en;
    logic sel_4v2;
    logic [6:0] limit_pct;
    logic [6:0] term_pct;
  } lics_regs_t;

  lics_regs_t r;
  lics_regs_t next_r;

  localparam logic [23:0] HALF_LAST = 24'(HALF_PERIOD - 1);

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic [14:0] bump(input logic [14:0] cnt, input logic adv);
    bump = (adv && cnt != 15'h7FFF) ? cnt + 15'h0001 : cnt;
  endfunction

  // ****************************************
  // combinational next state
  // ****************************************
  logic [IN_W-1:0] raw_in;
  logic lockout;
  logic en;
  logic temp_ok;
  logic base_tick;
  logic scaled_tick;
  logic adv;
  logic [4:0] acc_sum;
  logic [7:0] cap_eff;
  logic charging;
  logic bus_req;
  logic drive_chg;
  logic drive_flt;

  assign raw_in = {fault_indicator_in, charge_indicator_in, target_voltage_select,
                   die_thermal_regulation, current_below_termination, cell_below_recharge,
                   cell_at_regulation, cell_above_precondition, cell_temp_sense_disabled,
                   cell_temp_in_window, enable, supply_lockout};

  always_comb begin
    next_r = r;
    next_r.sync1 = raw_in;
    next_r.sync2 = r.sync1;
    lockout = r.sync2[IN_LOCKOUT];
    en = r.sync2[IN_ENABLE];
    temp_ok = r.sync2[IN_TEMP_OK] || r.sync2[IN_TEMP_OFF];
    charging = (r.state == LICS_PRECON) || (r.state == LICS_FAST) || (r.state == LICS_CV);

    // scaled time base: one tick per half flash period times capacitance
    base_tick = (r.prescale == HALF_LAST);
    next_r.prescale = base_tick ? 24'h000000 : r.prescale + 24'h000001;
    cap_eff = (r.cap_tenths == 8'h00) ? 8'h01 : r.cap_tenths;
    scaled_tick = 1'b0;
    if (base_tick) begin
      if (r.scale_cnt >= cap_eff - 8'h01) begin
        next_r.scale_cnt = 8'h00;
        scaled_tick = 1'b1;
      end else begin
        next_r.scale_cnt = r.scale_cnt + 8'h01;
      end
    end
    if (scaled_tick) begin
      next_r.flash = ~r.flash;
    end

    // under thermal regulation the timers advance at rate/16 of normal
    acc_sum = {1'b0, r.cell_temp_sense_acc} + {1'b0, r.thermal_rate};
    adv = 1'b0;
    if (scaled_tick && temp_ok) begin
      if (r.sync2[IN_THERMAL]) begin
        next_r.cell_temp_sense_acc = acc_sum[3:0];
        adv = acc_sum[4];
      end else begin
        adv = 1'b1;
      end
    end

    // ****************************************
    // charge cycle
    // ****************************************
    case (r.state)
      LICS_DISABLED: begin
        if (en) begin
          next_r.state = LICS_QUAL;
        end
      end
      LICS_QUAL: begin
        next_r.precon_cnt = 15'h0000;
        next_r.fast_cnt = 15'h0000;
        next_r.elapsed_cnt = 15'h0000;
        if (temp_ok) begin
          if (r.sync2[IN_ABOVE_PRECON]) begin
            next_r.state = LICS_FAST;
          end else begin
            next_r.state = LICS_PRECON;
          end
        end
      end
      LICS_PRECON: begin
        next_r.precon_cnt = bump(r.precon_cnt, adv);
        if (r.sync2[IN_ABOVE_PRECON]) begin
          next_r.state = LICS_FAST;
          next_r.precon_cnt = 15'h0000;
          next_r.fast_cnt = 15'h0000;
          next_r.elapsed_cnt = 15'h0000;
        end else if (r.precon_cnt >= PRECON_TICKS) begin
          next_r.state = LICS_FAULT;
        end
      end
      LICS_FAST: begin
        next_r.fast_cnt = bump(r.fast_cnt, adv);
        next_r.elapsed_cnt = bump(r.elapsed_cnt, adv);
        if (r.sync2[IN_AT_REG]) begin
          next_r.state = LICS_CV;
          next_r.fast_cnt = 15'h0000;
        end else if (r.fast_cnt >= FAST_TICKS) begin
          next_r.state = LICS_FAULT;
        end
      end
      LICS_CV: begin
        next_r.elapsed_cnt = bump(r.elapsed_cnt, adv);
        if (r.sync2[IN_BELOW_TERM] || r.elapsed_cnt >= ELAPSED_TICKS) begin
          next_r.state = LICS_DONE;
        end
      end
      LICS_DONE: begin
        if (r.sync2[IN_BELOW_RECHG] && temp_ok) begin
          next_r.state = LICS_QUAL;
        end
      end
      LICS_FAULT: begin
        next_r.state = LICS_FAULT;
      end
      default: begin
        next_r.state = LICS_DISABLED;
      end
    endcase

    // disable or lockout overrides every state, clearing the fault latch
    if (lockout || !en) begin
      next_r.state = LICS_DISABLED;
      next_r.precon_cnt = 15'h0000;
      next_r.fast_cnt = 15'h0000;
      next_r.elapsed_cnt = 15'h0000;
      next_r.cell_temp_sense_acc = 4'h0;
    end

    // ****************************************
    // drive controls and indicators
    // ****************************************
    next_r.precon_en = 1'b0;
    next_r.fast_en = 1'b0;
    next_r.cv_en = 1'b0;
    next_r.limit_pct = 7'h00;
    next_r.term_pct = TERM_PCT;
    next_r.sel_4v2 = r.sync2[IN_VSEL];
    // current stays off while suspended on temperature
    if (!lockout && en && temp_ok) begin
      case (next_r.state)
        LICS_PRECON: begin
          next_r.precon_en = 1'b1;
          next_r.limit_pct = PRECON_PCT;
        end
        LICS_FAST: begin
          next_r.fast_en = 1'b1;
          next_r.limit_pct = FAST_PCT;
        end
        LICS_CV: begin
          next_r.cv_en = 1'b1;
          next_r.limit_pct = FAST_PCT;
        end
        default: begin
          next_r.limit_pct = 7'h00;
        end
      endcase
    end

    drive_chg = 1'b0;
    drive_flt = 1'b0;
    if (r.variant_single) begin
      if (r.state == LICS_FAULT || (charging && !temp_ok)) begin
        drive_chg = r.flash;
      end else if (charging) begin
        drive_chg = 1'b1;
      end
    end else begin
      if (r.state == LICS_FAULT) begin
        // status table holds the fault output steady; option follows the prose
        drive_flt = r.fault_flash ? r.flash : 1'b1;
      end else if (charging && !temp_ok) begin
        drive_flt = r.flash;
      end else if (charging) begin
        drive_chg = 1'b1;
      end else if (r.state == LICS_DONE) begin
        drive_chg = r.flash;
      end
    end
    if (lockout) begin
      drive_chg = 1'b0;
      drive_flt = 1'b0;
    end
    next_r.chg_oe_n = ~drive_chg;
    next_r.flt_oe_n = ~drive_flt;

    // ****************************************
    // wishbone slave, one wait state
    // ****************************************
    bus_req = wb_cyc_i && wb_stb_i && !r.ack;
    next_r.ack = bus_req;
    next_r.dat = 32'h00000000;
    if (bus_req) begin
      if (wb_we_i) begin
        if (hit(wb_adr_i, REG_CTRL) && wb_sel_i[0]) begin
          next_r.variant_single = wb_dat_i[CTRL_SINGLE_BIT];
          next_r.fault_flash = wb_dat_i[CTRL_FLASH_FAULT_BIT];
        end
        if (hit(wb_adr_i, REG_SCALE)) begin
          if (wb_sel_i[0]) begin
            next_r.cap_tenths = wb_dat_i[SCALE_CAP_LSB +: 8];
          end
          if (wb_sel_i[1]) begin
            next_r.thermal_rate = wb_dat_i[SCALE_RATE_LSB +: 4];
          end
        end
      end else begin
        if (hit(wb_adr_i, REG_CTRL)) begin
          next_r.dat[CTRL_SINGLE_BIT] = r.variant_single;
          next_r.dat[CTRL_FLASH_FAULT_BIT] = r.fault_flash;
        end else if (hit(wb_adr_i, REG_SCALE)) begin
          next_r.dat[SCALE_CAP_LSB +: 8] = r.cap_tenths;
          next_r.dat[SCALE_RATE_LSB +: 4] = r.thermal_rate;
        end else if (hit(wb_adr_i, REG_STATUS)) begin
          next_r.dat[6:0] = r.state;
          next_r.dat[STATUS_TEMP_BAD_BIT] = ~temp_ok;
          next_r.dat[STATUS_PIN_LSB +: 2] = r.sync2[IN_FLT_PIN:IN_CHG_PIN];
        end else if (hit(wb_adr_i, REG_ELAPSED)) begin
          next_r.dat[14:0] = r.elapsed_cnt;
        end
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
      r.state <= LICS_DISABLED;
      r.cap_tenths <= CAP_TENTHS_RESET;
      r.thermal_rate <= THERMAL_RATE_RESET;
      r.chg_oe_n <= 1'b1;
      r.flt_oe_n <= 1'b1;
      r.term_pct <= TERM_PCT;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign charge_indicator_out = 1'b0;
  assign fault_indicator_out = 1'b0;
  assign charge_indicator_oe_n = r.chg_oe_n;
  assign fault_indicator_oe_n = r.flt_oe_n;
  assign precondition_current_en = r.precon_en;
  assign fast_current_en = r.fast_en;
  assign voltage_regulation_en = r.cv_en;
  assign target_4v2_sel = r.sel_4v2;
  assign current_limit_pct = r.limit_pct;
  assign termination_pct = r.term_pct;

endmodule

// ===== bench/lics_status_load.sv
// pull-up load on one open-drain status line
module lics_status_load (
  input wire logic oe_n,
  input wire logic drv,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released line is pulled high, it never keeps the sunk level
  assign pin = oe_n ? 1'h1 : drv;
endmodule

// ===== bench/lics_sequencer_asserts.sv
// port checks for the charge-cycle sequencer
module lics_sequencer_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic supply_lockout,
  input wire logic enable,
  input wire logic cell_temp_in_window,
  input wire logic cell_temp_sense_disabled,
  input wire logic target_voltage_select,
  input wire logic charge_indicator_out,
  input wire logic charge_indicator_oe_n,
  input wire logic fault_indicator_out,
  input wire logic fault_indicator_oe_n,
  input wire logic precondition_current_en,
  input wire logic fast_current_en,
  input wire logic voltage_regulation_en,
  input wire logic target_4v2_sel,
  input wire logic [6:0] current_limit_pct,
  input wire logic [6:0] termination_pct
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // ****************************************
  // checks
  // ****************************************
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray read data");
  // two sync flops plus state and output stages fit in five cycles
  lock_idle_a:
    assert property (supply_lockout [*5] |-> charge_indicator_oe_n && fault_indicator_oe_n
      && current_limit_pct == 7'h00) else $error("lockout ignored");
  disable_idle_a:
    assert property (!enable [*5] |-> charge_indicator_oe_n && !fast_current_en
      && !voltage_regulation_en) else $error("disable ignored");
  temp_hold_a:
    assert property ((!cell_temp_in_window && !cell_temp_sense_disabled) [*5]
      |-> current_limit_pct == 7'h00) else $error("charging while too hot or cold");
  precon_level_a:
    assert property (precondition_current_en |-> current_limit_pct == 7'h0A
      && !fast_current_en && !voltage_regulation_en) else $error("trickle level");
  fast_level_a:
    assert property (fast_current_en || voltage_regulation_en |-> current_limit_pct == 7'h64)
      else $error("fast level");
  term_level_a:
    assert property (termination_pct == 7'h07) else $error("taper level");
  drain_low_a:
    assert property (!charge_indicator_out && !fault_indicator_out) else $error("drain high");
  cv_sink_a:
    assert property (voltage_regulation_en |-> !charge_indicator_oe_n) else $error("led off");
  vsel_track_a:
    assert property ($stable(target_voltage_select) [*5]
      |-> target_4v2_sel == target_voltage_select) else $error("target select");
  cover property (voltage_regulation_en);
  cover property (!fault_indicator_oe_n && charge_indicator_oe_n);
  cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule

bind lics_sequencer lics_sequencer_asserts u_chk (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .supply_lockout, .enable, .cell_temp_in_window,
  .cell_temp_sense_disabled, .target_voltage_select, .charge_indicator_out,
  .charge_indicator_oe_n, .fault_indicator_out, .fault_indicator_oe_n,
  .precondition_current_en, .fast_current_en, .voltage_regulation_en, .target_4v2_sel,
  .current_limit_pct, .termination_pct);

// ===== bench/lics_sequencer_tb_top.sv
// self-checking bench for the charge-cycle sequencer
module lics_sequencer_tb_top;
  import lics_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, cap;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, e0;
  logic supply_lockout = 1'h0, enable = 1'h0, cell_temp_in_window = 1'h1;
  logic cell_temp_sense_disabled = 1'h0, cell_above_precondition = 1'h0;
  logic cell_at_regulation = 1'h0, cell_below_recharge = 1'h0, die_thermal_regulation = 1'h0;
  logic current_below_termination = 1'h0, target_voltage_select = 1'h0, wb_ack_o;
  logic charge_indicator_in, charge_indicator_out, charge_indicator_oe_n, fault_indicator_in;
  logic fault_indicator_out, fault_indicator_oe_n, precondition_current_en, fast_current_en;
  logic voltage_regulation_en, target_4v2_sel;
  logic [6:0] current_limit_pct, termination_pct;
  int fails = 0, checked = 0, cyc_cnt = 0;
  // short half period keeps the hour-long safety timers simulable
  lics_sequencer #(.HALF_PERIOD(4)) u_dut (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .supply_lockout, .enable,
    .cell_temp_in_window, .cell_temp_sense_disabled, .cell_above_precondition,
    .cell_at_regulation, .cell_below_recharge, .current_below_termination,
    .die_thermal_regulation, .target_voltage_select, .charge_indicator_in,
    .charge_indicator_out, .charge_indicator_oe_n, .fault_indicator_in, .fault_indicator_out,
    .fault_indicator_oe_n, .precondition_current_en, .fast_current_en, .voltage_regulation_en,
    .target_4v2_sel, .current_limit_pct, .termination_pct);
  lics_status_load u_chg (.oe_n(charge_indicator_oe_n), .drv(charge_indicator_out),
    .pin(charge_indicator_in));
  lics_status_load u_flt (.oe_n(fault_indicator_oe_n), .drv(fault_indicator_out),
    .pin(fault_indicator_in));
  always #25 sys_clk = ~sys_clk;
  // ****************************************
  // helpers
  // ****************************************
  task results;
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      fails++;
      results();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tk(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 50);
    q = wb_dat_o;
    if (k >= 50) fails++;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  function automatic logic [6:0] pct_of(input lics_state_t s);
    return s == LICS_PRECON ? PRECON_PCT : (s inside {LICS_FAST, LICS_CV}) ? FAST_PCT : 7'h00;
  endfunction
  // {fault, charge} enables of the two-output variant, low means sinking
  function automatic logic [1:0] oe_of(input lics_state_t s);
    return s == LICS_FAULT ? 2'h1 : (s inside {LICS_PRECON, LICS_FAST, LICS_CV}) ? 2'h2 : 2'h3;
  endfunction
  function automatic logic pick(input logic f);
    return f ? fault_indicator_oe_n : charge_indicator_oe_n;
  endfunction
  task automatic est(input lics_state_t s);
    wb(REG_STATUS, 1'h0, 32'h0);
    check(q[6:0], s);
    check(current_limit_pct, pct_of(s));
    check({fault_indicator_oe_n, charge_indicator_oe_n}, oe_of(s));
    check(q[10:9], oe_of(s));
  endtask
  // measures one full flash phase after the next edge of the line
  task automatic flash(input logic f, input int len);
    logic v;
    int k;
    v = pick(f);
    k = 0;
    while (pick(f) === v && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    v = ~v;
    k = 0;
    while (pick(f) === v && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    check(k, len);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    q = $urandom(32'h108B1315);
    tk(16);
    sys_rst <= 1'h0;
    // pin readback passes two sync stages that come out of reset low
    tk(2);
    est(LICS_DISABLED);
    wb(REG_SCALE, 1'h0, 32'h0);
    check(q, {20'h0, THERMAL_RATE_RESET, CAP_TENTHS_RESET});
    // byte enables: only the rate byte may change
    wb_sel_i <= 4'h2;
    wb(REG_SCALE, 1'h1, 32'h0000_0305);
    wb_sel_i <= 4'hF;
    wb(REG_SCALE, 1'h0, 32'h0);
    check(q, 32'h0000_0301);
    wb(REG_SCALE, 1'h1, 32'h0000_0801);
    wb(8'h10, 1'h1, 32'hFFFF_FFFF);
    wb(8'h10, 1'h0, 32'h0);
    check(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      target_voltage_select <= i[0];
      tk(6);
      check(target_4v2_sel, i[0]);
    end
    enable <= 1'h1;
    tk(10);
    est(LICS_PRECON);
    cell_above_precondition <= 1'h1;
    tk(8);
    est(LICS_FAST);
    for (int t = 0; t < 2; t++) begin
      die_thermal_regulation <= t[0];
      tk(6);
      wb(REG_ELAPSED, 1'h0, 32'h0);
      e0 = q;
      tk(400);
      wb(REG_ELAPSED, 1'h0, 32'h0);
      check((q - e0) inside {[(100 >> t) - 1:(100 >> t) + 1]}, 1'h1);
    end
    die_thermal_regulation <= 1'h0;
    cell_at_regulation <= 1'h1;
    tk(8);
    est(LICS_CV);
    cell_temp_in_window <= 1'h0;
    tk(8);
    wb(REG_STATUS, 1'h0, 32'h0);
    check(q[8:0], 9'h110);
    flash(1'h1, 4);
    cell_temp_sense_disabled <= 1'h1;
    tk(8);
    check(current_limit_pct, FAST_PCT);
    cell_temp_in_window <= 1'h1;
    cell_temp_sense_disabled <= 1'h0;
    current_below_termination <= 1'h1;
    cap = 8'(1 + $urandom % 3);
    wb(REG_SCALE, 1'h1, {20'h0, THERMAL_RATE_RESET, cap});
    tk(8);
    wb(REG_STATUS, 1'h0, 32'h0);
    check(q[6:0], LICS_DONE);
    flash(1'h0, 4 * cap);
    check(fault_indicator_oe_n, 1'h1);
    wb(REG_SCALE, 1'h1, 32'h801);
    current_below_termination <= 1'h0;
    cell_at_regulation <= 1'h0;
    cell_below_recharge <= 1'h1;
    tk(10);
    est(LICS_FAST);
    cell_below_recharge <= 1'h0;
    enable <= 1'h0;
    tk(8);
    est(LICS_DISABLED);
    cell_above_precondition <= 1'h0;
    enable <= 1'h1;
    tk(10);
    est(LICS_PRECON);
    tk(PRECON_TICKS * 4 - 50);
    est(LICS_PRECON);
    tk(100);
    est(LICS_FAULT);
    cell_above_precondition <= 1'h1;
    wb(REG_CTRL, 1'h1, 32'h2);
    flash(1'h1, 4);
    check(charge_indicator_oe_n, 1'h1);
    wb(REG_CTRL, 1'h1, 32'h1);
    flash(1'h0, 4);
    check(fault_indicator_oe_n, 1'h1);
    wb(REG_STATUS, 1'h0, 32'h0);
    check(q[6:0], LICS_FAULT);
    enable <= 1'h0;
    tk(8);
    enable <= 1'h1;
    tk(10);
    wb(REG_STATUS, 1'h0, 32'h0);
    check(q[6:0], LICS_FAST);
    check(charge_indicator_oe_n, 1'h0);
    supply_lockout <= 1'h1;
    tk(8);
    wb(REG_CTRL, 1'h1, 32'h0);
    est(LICS_DISABLED);
    wb(REG_ELAPSED, 1'h0, 32'h0);
    check(q[14:0], 15'h0);
    results();
  end
endmodule
